// ==== rtl/flash_host_defines.vh ====
// Constants for the flash command host controller
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
`define CMD_READ_ARRAY     8'hff
`define CMD_IDENTIFY       8'h90
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_ERASE_SETUP    8'h20
`define CMD_CONFIRM        8'hd0
`define CMD_PROGRAM_SETUP  8'h40
`define CMD_PROGRAM_ALT    8'h10
`define CMD_SUSPEND        8'hb0
`define NULL_WORD          16'hffff
`define ST_READY_BIT       7
`define ST_SUSPEND_BIT     6
`define ST_ERASE_ERR_BIT   5
`define ST_PROG_ERR_BIT    4
`define ST_VPP_ERR_BIT     3
`define ID_ADDR_MAKER      20'h00000
`define ID_ADDR_DEVICE     20'h00001
`define ADDR_CTRL          12'h000
`define ADDR_ADDR          12'h004
`define ADDR_WDATA         12'h008
`define ADDR_STATUS        12'h00c
`define ADDR_RDATA         12'h010
`define ADDR_PINS          12'h014
`define OP_READ            4'h0
`define OP_PROGRAM         4'h1
`define OP_ERASE           4'h2
`define OP_SUSPEND         4'h3
`define OP_RESUME          4'h4
`define OP_READ_STATUS     4'h5
`define OP_CLEAR_STATUS    4'h6
`define OP_READ_ARRAY      4'h7
`define OP_IDENTIFY        4'h8
`define OP_NULL_PROGRAM    4'h9
`define OP_RAW_CMD         4'ha
`define T_WE_PULSE_NS      50
`define T_WE_PULSE_CYC     ((`T_WE_PULSE_NS + 24) / 25)
`define T_ACCESS_NS        80
`define T_ACCESS_CYC       ((`T_ACCESS_NS + 24) / 25)
`endif

// ==== rtl/flash_bus_cycle.v ====
// One parallel write or read cycle on the flash pins
`include "flash_host_defines.vh"
module flash_bus_cycle
#(
   parameter WE_CYC  = `T_WE_PULSE_CYC,
   parameter ACC_CYC = `T_ACCESS_CYC
)
(
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   input  wire        start_i,
   input  wire        write_i,
   input  wire [19:0] addr_i,
   input  wire [15:0] wdata_i,
   input  wire [15:0] dq_i,
   output reg         done_o,
   output reg  [15:0] rdata_o,
   output reg  [19:0] addr_o,
   output reg  [15:0] dq_o,
   output reg         dq_oe_o,
   output reg         ce_n_o,
   output reg         we_n_o,
   output reg         oe_n_o
);
   reg  [3:0] cnt_r;
   reg  [1:0] ph_r;
   localparam P_IDLE = 2'h0;
   localparam P_ACT  = 2'h1;
   localparam P_END  = 2'h2;
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_r   <= 4'h0;
         ph_r    <= P_IDLE;
         done_o  <= 1'b0;
         rdata_o <= 16'h0000;
         addr_o  <= 20'h00000;
         dq_o    <= 16'h0000;
         dq_oe_o <= 1'b0;
         ce_n_o  <= 1'b1;
         we_n_o  <= 1'b1;
         oe_n_o  <= 1'b1;
      end
      else
      begin
         done_o <= 1'b0;
         case (ph_r)
            P_IDLE:
               if (start_i)
               begin
                  addr_o  <= addr_i;
                  dq_o    <= wdata_i;
                  dq_oe_o <= write_i;
                  ce_n_o  <= 1'b0;
                  we_n_o  <= ~write_i;
                  oe_n_o  <= write_i;
                  cnt_r   <= write_i ? WE_CYC[3:0] : ACC_CYC[3:0];
                  ph_r    <= P_ACT;
               end
            P_ACT:
               if (cnt_r <= 4'h1)
               begin
                  rdata_o <= dq_i;
                  we_n_o  <= 1'b1;
                  oe_n_o  <= 1'b1;
                  ph_r    <= P_END;
               end
               else
                  cnt_r <= cnt_r - 4'h1;
            P_END:
            begin
               // Chip enable goes high after every bus cycle and stays high until the next start, refreshing status output
               ce_n_o  <= 1'b1;
               dq_oe_o <= 1'b0;
               done_o  <= 1'b1;
               ph_r    <= P_IDLE;
            end
            default:
               ph_r <= P_IDLE;
         endcase
      end
   end
endmodule // flash_bus_cycle

// ==== rtl/flash_cmd_host.v ====
// Host controller issuing command sequences to a boot-block flash
// Functional notes
// - Write FFh to return to array read
// - Read 00h maker, 01h device code
// - Program: setup 40h/10h then address+data
// - Boot block needs unlock or write-protect high
// - Null program cancels after setup
// - Erase: 20h then D0h in block
// - Only suspend allowed during erase
//
// The APB register port and the register offsets are this design's own decisions.
`include "flash_host_defines.vh"
module flash_cmd_host
(
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [15:0] dq_i,
   output wire [15:0] dq_o,
   output wire        dq_oe_o,
   output wire [18:0] addr_o,
   output wire        ce_n_o,
   output wire        we_n_o,
   output wire        oe_n_o,
   output reg         reset_powerdown_n_o,
   output reg         unlock_hv_o,
   output reg         write_protect_n_o,
   output reg         vpp_en_o,
   output reg         byte_n_o
);
   // ***************************************************
   // Register file
   // ***************************************************
   reg  [19:0] addr_r;
   reg  [15:0] wdata_r;
   reg  [15:0] rdata_r;
   reg  [7:0]  status_r;
   reg         busy_r;
   reg         done_r;
   reg         err_r;
   reg  [3:0]  op_r;
   reg  [3:0]  state_r;
   reg  [7:0]  raw_r;
   reg         cyc_start_r;
   reg         cyc_write_r;
   reg  [19:0] cyc_addr_r;
   reg  [15:0] cyc_wdata_r;
   wire        cyc_done;
   wire [15:0] cyc_rdata;
   wire [19:0] pin_addr;
   wire [15:0] pin_dq;
   wire        pin_dq_oe;
   wire        acc = psel & penable;
   wire        wr_ctrl = acc & pwrite & (paddr == `ADDR_CTRL);

   // Decode of an 8-bit command into a bus write word
   function [15:0] cmd_word;
      input [7:0] c;
      begin
         cmd_word = {8'h00, c};
      end
   endfunction

   // Status bit that blocks a new program or erase: the VPP error bit
   function err_blocks;
      input [7:0] s;
      begin
         err_blocks = s[`ST_VPP_ERR_BIT];
      end
   endfunction

   // Byte mode low address on data line 15
   assign addr_o  = pin_addr[19:1] & {19{1'b1}};
   assign dq_o    = byte_n_o ? pin_dq : {pin_addr[0], 7'h00, pin_dq[7:0]};
   assign dq_oe_o = pin_dq_oe;

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         addr_r  <= 20'h00000;
         wdata_r <= 16'h0000;
         reset_powerdown_n_o <= 1'b0;
         unlock_hv_o       <= 1'b0;
         write_protect_n_o <= 1'b0;
         vpp_en_o          <= 1'b0;
         byte_n_o          <= 1'b1;
      end
      else
      begin
         pready  <= acc & ~pready;
         pslverr <= 1'b0;
         if (acc & ~pready)
         begin
            if (pwrite)
               case (paddr)
                  `ADDR_ADDR:  addr_r  <= pwdata[19:0];
                  `ADDR_WDATA: wdata_r <= pwdata[15:0];
                  `ADDR_PINS:
                  begin
                     reset_powerdown_n_o <= pwdata[0];
                     unlock_hv_o       <= pwdata[1];
                     write_protect_n_o <= pwdata[2];
                     vpp_en_o          <= pwdata[3];
                     byte_n_o          <= pwdata[4];
                  end
                  `ADDR_CTRL: ;
                  default: pslverr <= 1'b1;
               endcase
            else
               case (paddr)
                  `ADDR_CTRL:   prdata <= {16'h0000, raw_r, op_r, 4'h0};
                  `ADDR_ADDR:   prdata <= {12'h000, addr_r};
                  `ADDR_WDATA:  prdata <= {16'h0000, wdata_r};
                  `ADDR_STATUS: prdata <= {21'h0, err_r, done_r, busy_r,
                                           status_r};
                  `ADDR_RDATA:  prdata <= {16'h0000, rdata_r};
                  `ADDR_PINS:   prdata <= {27'h0, byte_n_o, vpp_en_o,
                                           write_protect_n_o, unlock_hv_o,
                                           reset_powerdown_n_o};
                  default:
                  begin
                     prdata  <= 32'h00000000;
                     pslverr <= 1'b1;
                  end
               endcase
         end
      end
   end

   // ***************************************************
   // Sequencer
   // ***************************************************
   localparam S_IDLE  = 4'h0;
   localparam S_CMD1  = 4'h1;
   localparam S_CMD2  = 4'h2;
   localparam S_POLL  = 4'h3;
   localparam S_RD    = 4'h4;
   localparam S_DONE  = 4'h5;
   localparam S_WAIT1 = 4'h6;
   localparam S_WAIT2 = 4'h7;
   localparam S_WAITP = 4'h8;
   localparam S_WAITR = 4'h9;

   wire two_cycle = (op_r == `OP_PROGRAM) | (op_r == `OP_ERASE) |
                    (op_r == `OP_NULL_PROGRAM);
   wire polled    = (op_r == `OP_PROGRAM) | (op_r == `OP_ERASE) |
                    (op_r == `OP_SUSPEND) | (op_r == `OP_RESUME);

   reg [7:0] first_cmd;
   always @*
   begin
      case (op_r)
         `OP_PROGRAM, `OP_NULL_PROGRAM: first_cmd = `CMD_PROGRAM_SETUP;
         `OP_ERASE:        first_cmd = `CMD_ERASE_SETUP;
         // Suspend is the only erase-time command
         `OP_SUSPEND:      first_cmd = `CMD_SUSPEND;
         // Resume may follow suspend at once
         `OP_RESUME:       first_cmd = `CMD_CONFIRM;
         `OP_READ_STATUS:  first_cmd = `CMD_READ_STATUS;
         `OP_CLEAR_STATUS: first_cmd = `CMD_CLEAR_STATUS;
         `OP_IDENTIFY:     first_cmd = `CMD_IDENTIFY;
         `OP_RAW_CMD:      first_cmd = raw_r;
         default:          first_cmd = `CMD_READ_ARRAY;
      endcase
   end

   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r     <= S_IDLE;
         op_r        <= `OP_READ;
         raw_r       <= 8'h00;
         busy_r      <= 1'b0;
         done_r      <= 1'b0;
         err_r       <= 1'b0;
         status_r    <= 8'h80;
         rdata_r     <= 16'h0000;
         cyc_start_r <= 1'b0;
         cyc_write_r <= 1'b0;
         cyc_addr_r  <= 20'h00000;
         cyc_wdata_r <= 16'h0000;
      end
      else
      begin
         cyc_start_r <= 1'b0;
         case (state_r)
            S_IDLE:
               if (wr_ctrl & ~pready)
               begin
                  op_r   <= pwdata[7:4];
                  raw_r  <= pwdata[15:8];
                  busy_r <= 1'b1;
                  done_r <= 1'b0;
                  err_r  <= 1'b0;
                  state_r <= S_CMD1;
               end
            S_CMD1:
               if ((op_r == `OP_PROGRAM | op_r == `OP_ERASE) &
                   err_blocks(status_r))
               begin
                  err_r   <= 1'b1;
                  state_r <= S_DONE;
               end
               else if (op_r == `OP_READ)
               begin
                  // Plain read in the current mode
                  cyc_write_r <= 1'b0;
                  cyc_addr_r  <= addr_r;
                  cyc_start_r <= 1'b1;
                  state_r     <= S_WAITR;
               end
               else
               begin
                  cyc_write_r <= 1'b1;
                  cyc_addr_r  <= addr_r;
                  cyc_wdata_r <= cmd_word(first_cmd);
                  cyc_start_r <= 1'b1;
                  state_r     <= S_WAIT1;
               end
            S_WAIT1:
               if (cyc_done)
                  state_r <= two_cycle ? S_CMD2 :
                             (polled ? S_POLL : S_DONE);
            S_CMD2:
            begin
               cyc_write_r <= 1'b1;
               cyc_addr_r  <= addr_r;
               // Confirm at address in target block
               cyc_wdata_r <= (op_r == `OP_NULL_PROGRAM) ? `NULL_WORD :
                              (op_r == `OP_ERASE) ? cmd_word(`CMD_CONFIRM) :
                              wdata_r;
               cyc_start_r <= 1'b1;
               state_r     <= S_WAIT2;
            end
            S_WAIT2:
               if (cyc_done)
                  state_r <= (op_r == `OP_NULL_PROGRAM) ? S_DONE : S_POLL;
            S_POLL:
            begin
               // Any read returns status while busy
               cyc_write_r <= 1'b0;
               cyc_start_r <= 1'b1;
               state_r     <= S_WAITP;
            end
            S_WAITP:
               if (cyc_done)
               begin
                  status_r <= cyc_rdata[7:0];
                  if (cyc_rdata[`ST_READY_BIT])
                  begin
                     err_r   <= |cyc_rdata[`ST_ERASE_ERR_BIT:`ST_VPP_ERR_BIT];
                     state_r <= S_DONE;
                  end
                  else
                     state_r <= S_POLL;
               end
            S_WAITR:
               if (cyc_done)
               begin
                  rdata_r <= cyc_rdata;
                  if (op_r == `OP_READ_STATUS)
                     status_r <= cyc_rdata[7:0];
                  state_r <= S_DONE;
               end
            S_DONE:
            begin
               if (op_r == `OP_CLEAR_STATUS)
                  status_r <= status_r & 8'hc7;
               busy_r  <= 1'b0;
               done_r  <= 1'b1;
               state_r <= S_IDLE;
            end
            default:
               state_r <= S_IDLE;
         endcase
         if (state_r == S_WAIT1 & cyc_done & op_r == `OP_READ_STATUS)
            state_r <= S_CMD1;
         if (state_r == S_WAIT1 & cyc_done & op_r == `OP_READ_STATUS)
            op_r <= `OP_READ;
      end
   end

   flash_bus_cycle u_cycle
   (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .start_i   (cyc_start_r),
      .write_i   (cyc_write_r),
      .addr_i    (cyc_addr_r),
      .wdata_i   (cyc_wdata_r),
      .dq_i      (dq_i),
      .done_o    (cyc_done),
      .rdata_o   (cyc_rdata),
      .addr_o    (pin_addr),
      .dq_o      (pin_dq),
      .dq_oe_o   (pin_dq_oe),
      .ce_n_o    (ce_n_o),
      .we_n_o    (we_n_o),
      .oe_n_o    (oe_n_o)
   );
endmodule // flash_cmd_host

// ==== bench/flash_cmd_host_properties.sv ====
// Port checker for the flash command host
module flash_cmd_host_props
(
   input wire        ref_clk_i,
   input wire        reset_n_i,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire [15:0] dq_o,
   input wire        dq_oe_o,
   input wire        ce_n_o,
   input wire        we_n_o,
   input wire        oe_n_o,
   input wire        reset_powerdown_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_one_wait;
      psel && $rose(penable) |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("late pready");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_we_frame;
      !we_n_o |-> !ce_n_o && dq_oe_o && oe_n_o;
   endproperty
   a_we_frame: assert property (p_we_frame) else $error("bad write frame");
   property p_we_width;
      $fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write width");
   property p_release;
      $rose(we_n_o) |=> ce_n_o && !dq_oe_o;
   endproperty
   a_release: assert property (p_release) else $error("no release");
   property p_hold;
      !we_n_o && $past(!we_n_o) |-> $stable(dq_o);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_oe_width;
      $fell(oe_n_o) |-> !oe_n_o [*4] ##1 oe_n_o;
   endproperty
   a_oe_width: assert property (p_oe_width) else $error("read width");
   property p_pdn;
      !reset_powerdown_n_o |-> we_n_o && oe_n_o;
   endproperty
   a_pdn: assert property (p_pdn) else $error("cycle in power-down");
   c_write: cover property ($fell(we_n_o));
   c_read: cover property ($fell(oe_n_o));
   c_err: cover property (pslverr);
endmodule // flash_cmd_host_props
bind flash_cmd_host flash_cmd_host_props u_props
(
   .ref_clk_i, .reset_n_i, .psel, .penable, .pready, .pslverr, .dq_o,
   .dq_oe_o, .ce_n_o, .we_n_o, .oe_n_o, .reset_powerdown_n_o
);

// ==== bench/flash_device_model.sv ====
// Behavioural flash device facing the host
`include "flash_host_defines.vh"
module flash_device_model
#(
   parameter logic [15:0] MAKER_CODE  = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h005a  // Arbitrary value
)
(
   input  wire logic [18:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        reset_powerdown_n_i,
   input  wire logic        unlock_hv_i,
   input  wire logic        write_protect_n_i,
   input  wire logic        vpp_en_i,
   output      logic [15:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:1023];
   logic [7:0]  sr = 8'h80;
   logic [15:0] rd = 16'h0000;
   logic [18:0] wa;
   logic [15:0] wd;
   logic [7:0]  c;
   logic        lk;
   logic        susp = 0;
   int          mode = 0;
   int          pend = 0;
   int          left = 0;
   int          k = 0;
   function automatic logic [9:0] idx(input logic [18:0] a);
      return {a[12:11], a[7:0]};
   endfunction
   initial
      for (int i = 0; i < 1024; i++)
         mem[i] = 16'hffff;
   always @(negedge reset_powerdown_n_i or posedge we_n_i)
   begin
      c = dq_i[7:0];
      lk = addr_i[18:11] == 0 && !unlock_hv_i && !write_protect_n_i;
      if (!reset_powerdown_n_i)
      begin
         mode = 0;
         pend = 0;
         left = 0;
         susp = 0;
         sr = 8'h80;
      end
      else if (!ce_n_i && left > 0 && !sr[6])
         susp = k == 2 && (c == `CMD_SUSPEND || (susp && c != `CMD_CONFIRM));
      else if (!ce_n_i && pend != 0)
      begin
         k = pend;
         pend = 0;
         mode = 2;
         if (k == 2 && c != `CMD_CONFIRM)
            sr[5:4] = 2'b11;
         // Null, blocked, vpp and boot lock
         else if (!(k == 1 && dq_i == `NULL_WORD) && !sr[3])
         begin
            sr[3] = !vpp_en_i;
            sr[k + 3] = sr[k + 3] | sr[3] | lk;
            if (!sr[3] && !lk)
            begin
               wa = addr_i;
               wd = dq_i;
               left = 20 * k;
               sr[7] = 0;
            end
         end
      end
      else if (!ce_n_i)
         case (c)
            `CMD_READ_ARRAY:   mode = 0;
            `CMD_IDENTIFY:     mode = 1;
            `CMD_READ_STATUS:  mode = 2;
            `CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
            `CMD_ERASE_SETUP:  pend = 2;
            `CMD_PROGRAM_SETUP, `CMD_PROGRAM_ALT: pend = 1;
            `CMD_CONFIRM:
            begin
               // Resumed erase reports status until the next command
               sr[7:6] = {!sr[6], 1'b0};
               mode = 2;
            end
         endcase
   end
   always #100
   begin
      if (susp)
      begin
         sr[7:6] = 2'b11;
         susp = 0;
      end
      else if (left > 0 && !sr[6])
      begin
         left--;
         if (left == 0 && k == 1)
            mem[idx(wa)] = mem[idx(wa)] & wd;
         for (int i = 0; i < 256; i++)
            if (left == 0 && k == 2)
               mem[{wa[12:11], i[7:0]}] = 16'hffff;
         sr[7] = left == 0;
      end
   end
   always @(negedge oe_n_i or negedge ce_n_i)
      if ((left > 0 && !sr[6]) || mode == 2)
         rd = {8'h00, sr};
      else if (mode == 1)
         rd = addr_i[0] ? DEVICE_CODE : MAKER_CODE;
      else
         rd = mem[idx(addr_i)];
   assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
endmodule // flash_device_model

// ==== bench/test_flash_cmd_host.sv ====
// Self-checking bench for the flash command host
`include "flash_host_defines.vh"
module test_flash_cmd_host;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
   localparam logic [15:0] DEVID = 16'h005a; // Arbitrary value
   logic        ref_clk_i = 0;
   logic        reset_n_i = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] r;
   logic        e;
   logic [15:0] ref_mem [int];
   int          bad_count = 0;
   int          checks_done = 0;
   wire  [31:0] prdata;
   wire  [15:0] dq_o, dev_dq;
   wire  [18:0] addr_o;
   wire         pready, pslverr, dq_oe_o, ce_n_o, we_n_o, oe_n_o;
   wire         reset_powerdown_n_o, unlock_hv_o, write_protect_n_o;
   wire         vpp_en_o, byte_n_o;
   wire  [15:0] dq_bus = dq_oe_o ? dq_o : dev_dq;
   flash_cmd_host u_dut
   (
      .ref_clk_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .dq_i(dq_bus), .dq_o, .dq_oe_o, .addr_o,
      .ce_n_o, .we_n_o, .oe_n_o, .reset_powerdown_n_o, .unlock_hv_o,
      .write_protect_n_o, .vpp_en_o, .byte_n_o
   );
   flash_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) u_dev
   (
      .addr_i(addr_o), .dq_i(dq_bus), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
      .oe_n_i(oe_n_o), .reset_powerdown_n_i(reset_powerdown_n_o),
      .unlock_hv_i(unlock_hv_o), .write_protect_n_i(write_protect_n_o),
      .vpp_en_i(vpp_en_o), .dq_o(dev_dq)
   );
   always #12.5 ref_clk_i = ~ref_clk_i;
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic limit(input int n, input int m);
      if (n >= m)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: wait timed out", $time);
         test_done();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      limit(n, 50);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk_i);
   endtask
   task automatic op(input logic [3:0] o, input logic [19:0] a = 0,
                     input logic [15:0] d = 0, input logic [7:0] c = 0);
      int n;
      apb(1, `ADDR_ADDR, {12'h0, a});
      apb(1, `ADDR_WDATA, {16'h0, d});
      apb(1, `ADDR_CTRL, {16'h0, c, o, 4'h0});
      n = 0;
      do
      begin
         apb(0, `ADDR_STATUS, 0);
         n++;
      end
      while (r[8] !== 1'b0 && n < 100);
      limit(n, 100);
   endtask
   task automatic fr(input logic [19:0] a);
      op(`OP_READ, a);
      apb(0, `ADDR_RDATA, 0);
   endtask
   task automatic st;
      op(`OP_READ_STATUS);
      fr(0);
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         st();
         n++;
      end
      while (r[7] !== 1'b1 && n < 40);
      limit(n, 40);
   endtask
   function automatic logic [15:0] rm(input logic [19:0] a);
      return ref_mem.exists(a) ? ref_mem[a] : 16'hffff;
   endfunction
   task automatic prog(input logic [19:0] a, input logic [15:0] d, bit ok);
      op(`OP_PROGRAM, a, d);
      wait_ready();
      if (ok)
         ref_mem[a] = rm(a) & d;
   endtask
   task automatic wipe(input logic [7:0] b);
      foreach (ref_mem[k])
         if (k[19:12] == b)
            ref_mem[k] = 16'hffff;
   endtask
   task automatic cmp_all;
      op(`OP_READ_ARRAY);
      foreach (ref_mem[k])
      begin
         fr(k);
         check(r[15:0], ref_mem[k]);
      end
   endtask
   initial
   begin
      void'($urandom(75));
      repeat (8) @(posedge ref_clk_i);
      reset_n_i <= 1;
      @(posedge ref_clk_i);
      apb(1, `ADDR_PINS, 32'h19);
      apb(0, 12'h020, 0);
      check({15'h0, e}, 16'h0001);
      fr(20'h01234);
      check(r[15:0], 16'hffff);
      op(`OP_IDENTIFY);
      fr(`ID_ADDR_MAKER);
      check(r[15:0], MAKER);
      fr(20'h00002);
      check(r[15:0], DEVID);
      $display("test 1 done");
      for (int i = 0; i < 6; i++)
         prog({8'(1 + i % 2), 3'h0, 8'($urandom), 1'b0}, 16'($urandom), 1);
      st();
      check(r[15:0], 16'h0080);
      cmp_all();
      op(`OP_ERASE, 20'h01000);
      wait_ready();
      wipe(8'h01);
      cmp_all();
      $display("test 2 done");
      op(`OP_RAW_CMD, 0, 0, `CMD_ERASE_SETUP);
      op(`OP_RAW_CMD, 0, 0, `CMD_IDENTIFY);
      st();
      check(r[15:0], 16'h00b0);
      op(`OP_CLEAR_STATUS);
      st();
      check(r[15:0], 16'h0080);
      apb(1, `ADDR_PINS, 32'h11);
      prog(20'h02010, 16'h1234, 0);
      st();
      check(r[15:0], 16'h0098);
      apb(1, `ADDR_PINS, 32'h19);
      prog(20'h02010, 16'h0f0f, 0);
      st();
      check(r[15:0], 16'h0098);
      cmp_all();
      op(`OP_CLEAR_STATUS);
      $display("test 3 done");
      prog(20'h00020, 16'h5a5a, 0);
      st();
      check(r[15:0], 16'h0090);
      op(`OP_CLEAR_STATUS);
      apb(1, `ADDR_PINS, 32'h1d);
      prog(20'h00020, 16'h5a5a, 1);
      apb(1, `ADDR_PINS, 32'h1b);
      prog(20'h00040, 16'h3c3c, 1);
      apb(1, `ADDR_PINS, 32'h19);
      op(`OP_NULL_PROGRAM, 20'h00020);
      cmp_all();
      $display("test 4 done");
      // Raw setup and confirm, so the erase is still running at suspend
      op(`OP_RAW_CMD, 20'h02000, 0, `CMD_ERASE_SETUP);
      op(`OP_RAW_CMD, 20'h02000, 0, `CMD_CONFIRM);
      op(`OP_SUSPEND);
      st();
      check(r[15:0], 16'h00c0);
      op(`OP_READ_ARRAY);
      fr(20'h00020);
      check(r[15:0], rm(20'h00020));
      op(`OP_RESUME);
      wait_ready();
      check(r[15:0], 16'h0080);
      wipe(8'h02);
      cmp_all();
      op(`OP_READ_STATUS);
      apb(1, `ADDR_PINS, 32'h18);
      apb(1, `ADDR_PINS, 32'h19);
      fr(20'h00040);
      check(r[15:0], rm(20'h00040));
      $display("test 5 done");
      test_done();
   end
endmodule // test_flash_cmd_host
